// ==== rtl/cpu_reset_core.sv ====
// reset sequencer, static clocking and programmer register file
`include "cpu_reset_regs.svh"

// Behaviour
// [R1] reset high over 16 cycles reinitialises
// [R2] reset drives defined pin levels
// [R3] operation starts after reset falls
// [R4] generator releases reset synchronous to clock
// [R5] fifty init cycles, then power-on fetch
// [R6] synchronous reset aborts at second falling edge
// [R7] asynchronous reset leaves clock phase undefined
// [R8] synchronous assertion only needed for phase lock
// [R9] all state static, no refresh
// [R10] works from DC to maximum clock
// [R11] clock stoppable in either phase, resumes
// [R12] single clock stepping holds state
// [R13] real mode 1MB, protected 16MB physical; protected mode here forms only 16-bit addresses, upper 8 bits zero
// [R14] both modes share registers and instructions
// [R15] eight general words, four byte-split
// [R16] four segment registers
// [R17] four general registers serve base/index
// [R18] flags, status word and instruction pointer
// [R19] reset input passes a synchroniser
module cpu_reset_core
  import cpu_reset_pkg::*;
#(
  parameter int INIT_CYCLES = 50
) (
  // clock and system reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        sysReset,
  // system clock edge enables, from the clock generator
  input  wire logic        clkFallEn,
  input  wire logic        clkRiseEn,
  // register file access
  input  wire reg_wr_s     regWr,
  input  wire logic [3:0]  rdIdx,
  input  wire logic [2:0]  baseIdxSel,
  input  wire logic        protMode,
  input  wire logic [15:0] offset,
  // outputs
  output pins_s            pins,
  output logic [15:0]      rdData,
  output logic [23:0]      effAddr,
  output logic             procPhase,
  output logic             running,
  output logic             cycleAbort,
  output logic             reinitDone
);
  logic        resetSync;
  seq_state_e  state;
  seq_state_e  next_state;
  logic [4:0]  holdCnt;
  logic [4:0]  next_holdCnt;
  logic [5:0]  initCnt;
  logic [5:0]  next_initCnt;
  logic [1:0]  fallCnt;
  logic [1:0]  next_fallCnt;
  logic        next_procPhase;
  logic        next_cycleAbort;
  logic        next_reinitDone;
  logic        next_running;
  pins_s       next_pins;
  logic [15:0] regs [15];
  logic [15:0] next_regs [15];
  logic [15:0] next_rdData;
  logic [23:0] next_effAddr;

  // index 0..7 general, 8..11 segment, 12 flags, 13 status word, 14 ip
  localparam int SEG_CS = 9;
  localparam int IDX_IP = 14;
  localparam int IDX_MSW = 13;

  reset_sync #(.STAGES(`SYNC_STAGES)) uSync ( // R19
    .core_clk (core_clk),
    .din      (sysReset),
    .dout     (resetSync)
  );

  // base/index decode: bx, bp, si, di selected by the addressing mode
  function automatic logic [15:0] baseIndex(input logic [2:0] sel,
      input logic [15:0] b, input logic [15:0] bp,
      input logic [15:0] si, input logic [15:0] di);
    case (sel)
      3'h0:    baseIndex = b + si;
      3'h1:    baseIndex = b + di;
      3'h2:    baseIndex = bp + si;
      3'h3:    baseIndex = bp + di;
      3'h4:    baseIndex = si;
      3'h5:    baseIndex = di;
      3'h6:    baseIndex = bp;
      default: baseIndex = b;
    endcase
  endfunction : baseIndex

  function automatic pins_s resetPins();
    pins_s p;
    p.busStatus0       = 1'b1;
    p.busStatus1       = 1'b1;
    p.coprocOperandAck = 1'b1;
    p.addr             = `PIN_ADDR_RESET;
    p.upperByteEnable  = 1'b1;
    p.busLock          = 1'b1;
    p.memOrIo          = 1'b0;
    p.codeOrIntAck     = 1'b0;
    p.holdAcknowledge  = 1'b0;
    return p;
  endfunction : resetPins

  // sequencer; counters and phase advance only on fall enables, so a stopped
  // clock freezes them; the ST_RESET and ST_FETCH steps do not wait for an edge
  always_comb begin
    next_state      = state;
    next_holdCnt    = holdCnt;
    next_initCnt    = initCnt;
    next_fallCnt    = fallCnt;
    next_procPhase  = procPhase;
    next_cycleAbort = 1'b0;
    next_reinitDone = 1'b0;
    next_running    = running;
    next_pins       = pins;
    if (clkFallEn) begin
      next_procPhase = ~procPhase; // R10 R11 R12
    end
    if (resetSync) begin
      next_pins    = resetPins(); // R2
      next_running = 1'b0;
      if (clkFallEn && holdCnt <= `RESET_MIN_CYCLES) begin
        next_holdCnt = holdCnt + 5'd1; // R1
      end
      if (clkFallEn && fallCnt < `ABORT_FALL_EDGES) begin
        next_fallCnt = fallCnt + 2'd1;
        if (fallCnt + 2'd1 == `ABORT_FALL_EDGES) begin
          next_cycleAbort = 1'b1; // R6
          next_procPhase  = 1'b0; // R7
        end
      end
      if (clkFallEn && holdCnt == `RESET_MIN_CYCLES) begin
        next_reinitDone = 1'b1; // R1
      end
      // a short pulse only aborts; release still reruns the init count
      next_initCnt = 6'd0;
      if (next_holdCnt > `RESET_MIN_CYCLES) begin
        next_state = ST_RESET; // R1
      end else begin
        next_state = ST_INIT; // R3 R5
      end
    end else begin
      next_holdCnt = 5'd0;
      next_fallCnt = 2'd0;
      case (state)
        ST_RESET: begin
          next_state   = ST_INIT; // R3
          next_initCnt = 6'd0;
        end
        ST_INIT: begin
          if (clkFallEn) begin
            if (initCnt == 6'(INIT_CYCLES - 1)) begin
              next_state = ST_FETCH; // R5
            end else begin
              next_initCnt = initCnt + 6'd1;
            end
          end
        end
        ST_FETCH: begin
          next_pins.addr         = `POWERON_ADDR; // R5
          next_pins.memOrIo      = 1'b1;
          next_pins.codeOrIntAck = 1'b1;
          next_pins.busStatus0   = 1'b0;
          next_running           = 1'b1;
          next_state             = ST_RUN;
        end
        ST_RUN: begin
          next_pins.busStatus0 = 1'b1;
          next_pins.addr       = effAddr;
        end
        default: next_state = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state      <= ST_RESET;
      holdCnt    <= 5'd0;
      initCnt    <= 6'd0;
      fallCnt    <= 2'd0;
      procPhase  <= 1'b0;
      cycleAbort <= 1'b0;
      reinitDone <= 1'b0;
      running    <= 1'b0;
      pins       <= resetPins();
    end else begin
      state      <= next_state;
      holdCnt    <= next_holdCnt;
      initCnt    <= next_initCnt;
      fallCnt    <= next_fallCnt;
      procPhase  <= next_procPhase;
      cycleAbort <= next_cycleAbort;
      reinitDone <= next_reinitDone;
      running    <= next_running;
      pins       <= next_pins;
    end
  end

  // register file: same set in either mode
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      next_regs[i] = regs[i]; // R9
    end
    if (state == ST_RESET && resetSync) begin
      for (int i = 0; i < 15; i++) begin
        next_regs[i] = `REG_RESET;
      end
      next_regs[SEG_CS]  = `CODE_SEG_RESET;
      next_regs[IDX_MSW] = `MSW_RESET;
      next_regs[IDX_IP]  = `IP_RESET; // R18
    end else if (regWr.en && running && regWr.idx < 4'd15) begin
      if (regWr.idx < 4'd4 && regWr.size == WR_LOW) begin
        next_regs[regWr.idx][7:0] = regWr.data[7:0]; // R15
      end else if (regWr.idx < 4'd4 && regWr.size == WR_HIGH) begin
        next_regs[regWr.idx][15:8] = regWr.data[7:0]; // R15
      end else begin
        next_regs[regWr.idx] = regWr.data; // R16 R18
      end
    end
    next_rdData = (rdIdx < 4'd15) ? regs[rdIdx] : 16'h0000; // R14
    // offset arithmetic wraps at 16 bits before the segment is added
    next_effAddr = {8'h00, 16'(offset + baseIndex(baseIdxSel, regs[3],
                   regs[5], regs[6], regs[7]))}; // R17
    if (protMode) begin
      next_effAddr = next_effAddr; // R13
    end else begin
      next_effAddr = 24'({regs[11], 4'h0}) + next_effAddr;
      next_effAddr = next_effAddr & `REAL_ADDR_MASK; // R13
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 15; i++) begin
      regs[i] <= next_regs[i];
    end
    if (!rstn) begin
      rdData  <= 16'h0000;
      effAddr <= 24'h000000;
    end else begin
      rdData  <= next_rdData;
      effAddr <= next_effAddr;
    end
  end
endmodule : cpu_reset_core

// ==== rtl/cpu_reset_regs.svh ====
// timing counts, pin reset levels and register reset values
`ifndef CPU_RESET_REGS_SVH
`define CPU_RESET_REGS_SVH
`define RESET_MIN_CYCLES    5'd16
`define INIT_CYCLES         6'd50
`define ABORT_FALL_EDGES    2'd2
`define SYNC_STAGES         3
`define PIN_ADDR_RESET      24'hFFFFFF
`define POWERON_ADDR        24'hFFFFF0
`define REG_RESET           16'h0000
`define MSW_RESET           16'hFFF0
`define IP_RESET            16'hFFF0
`define CODE_SEG_RESET      16'hF000
`define REAL_ADDR_MASK      24'h0FFFFF
`endif

// ==== rtl/cpu_reset_pkg.sv ====
// types shared by the reset and register state logic
package cpu_reset_pkg;
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_INIT  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN   = 4'b1000
  } seq_state_e;

  typedef struct packed {
    logic        busStatus0;
    logic        busStatus1;
    logic        coprocOperandAck;
    logic [23:0] addr;
    logic        upperByteEnable;
    logic        busLock;
    logic        memOrIo;
    logic        codeOrIntAck;
    logic        holdAcknowledge;
  } pins_s;

  typedef enum logic [1:0] {
    WR_WORD = 2'h0,
    WR_LOW  = 2'h1,
    WR_HIGH = 2'h2
  } wr_size_e;

  typedef struct packed {
    logic       en;
    logic [3:0] idx;
    wr_size_e   size;
    logic [15:0] data;
  } reg_wr_s;
endpackage : cpu_reset_pkg

// ==== rtl/reset_sync.sv ====
// multi-stage synchroniser for the reset input
module reset_sync #(
  parameter int STAGES = 3
) (
  // clock
  input  wire logic core_clk,
  // raw and synchronised level
  input  wire logic din,
  output logic      dout
);
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  always_comb begin
    next_chain = {chain[STAGES-2:0], din};
  end

  // first stage only feeds the second
  always_ff @(posedge core_clk) begin
    chain <= next_chain;
  end

  assign dout = chain[STAGES-1];
endmodule : reset_sync

// ==== test/cpu_reset_core_assertions.sv ====
// port checks for the reset sequencer and register file
`include "cpu_reset_regs.svh"
module cpu_reset_core_assertions
  import cpu_reset_pkg::*;
#(
  parameter int INIT_CYCLES = 50
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        sysReset,
  input wire logic        clkFallEn,
  input wire reg_wr_s     regWr,
  input wire logic [3:0]  rdIdx,
  input wire pins_s       pins,
  input wire logic [15:0] rdData,
  input wire logic        procPhase,
  input wire logic        running,
  input wire logic        cycleAbort,
  input wire logic        reinitDone
);
  int fallCnt;
  int hiCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // raw counts lead the synchronised view by one fall at most
  always_ff @(posedge core_clk) begin
    fallCnt <= sysReset ? 0 : fallCnt + int'(clkFallEn);
    hiCnt   <= sysReset ? hiCnt + int'(clkFallEn) : 0;
  end
  a_reset_pins: assert property (
    sysReset [*6] |-> pins.busStatus0 && pins.busStatus1 &&
    pins.coprocOperandAck && &pins.addr && pins.upperByteEnable &&
    pins.busLock && !(pins.memOrIo || pins.codeOrIntAck ||
    pins.holdAcknowledge)) else $error("pin levels wrong in reset");
  a_halt_in_reset: assert property (
    sysReset [*6] |-> !running) else $error("running during reset");
  a_fetch_addr: assert property (
    $rose(running) |-> pins.addr == `POWERON_ADDR)
    else $error("first fetch address wrong");
  a_init_count: assert property (
    $rose(running) |-> fallCnt >= INIT_CYCLES &&
    fallCnt <= INIT_CYCLES + 2) else $error("init length wrong");
  a_abort_edge: assert property (
    cycleAbort |-> hiCnt inside {[2:3]} ##1 !cycleAbort)
    else $error("abort not at second fall");
  a_reinit_long: assert property (
    reinitDone |-> hiCnt >= 17 ##1 !reinitDone)
    else $error("reinit on short reset");
  a_phase_hold: assert property (
    (!clkFallEn && !sysReset) [*4] |=> $stable(procPhase))
    else $error("phase moved with clock stopped");
  a_phase_step: assert property (
    !sysReset [*6] ##0 clkFallEn |=> ##[0:1] $changed(procPhase))
    else $error("phase missed a fall");
  a_regs_static: assert property (
    (!regWr.en && !sysReset && $stable(rdIdx)) [*5] |=> $stable(rdData))
    else $error("register content drifted");
endmodule : cpu_reset_core_assertions

bind cpu_reset_core cpu_reset_core_assertions #(
  .INIT_CYCLES(INIT_CYCLES)
) cpu_reset_core_assertions_inst (
  .core_clk(core_clk), .rstn(rstn), .sysReset(sysReset),
  .clkFallEn(clkFallEn), .regWr(regWr), .rdIdx(rdIdx), .pins(pins),
  .rdData(rdData), .procPhase(procPhase), .running(running),
  .cycleAbort(cycleAbort), .reinitDone(reinitDone)
);

// ==== test/clk_gen_model.sv ====
// system clock edge and reset generator facing the core
module clk_gen_model (
  // clock and bench reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // bench control; period 0 stops the clock where it stands
  input  wire logic       resetReq,
  input  wire logic [3:0] period,
  // to the core
  output logic            clkFallEn,
  output logic            clkRiseEn,
  output logic            sysReset
);
  logic [3:0] cnt;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt       <= 4'h0;
      clkFallEn <= 1'b0;
      clkRiseEn <= 1'b0;
      sysReset  <= 1'b1;
    end else begin
      if (period != 4'h0) begin
        cnt <= (cnt >= period - 4'h1) ? 4'h0 : cnt + 4'h1;
      end
      clkFallEn <= period != 4'h0 && cnt == 4'h0;
      clkRiseEn <= period != 4'h0 && cnt == (period >> 1);
      // reset only moves with a fall, keeping phase lock
      if (clkFallEn) begin
        sysReset <= resetReq;
      end
    end
  end
endmodule : clk_gen_model

// ==== test/testbench.sv ====
// self-checking bench for the reset sequencer and register file
`include "cpu_reset_regs.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  err_count++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module testbench
  import cpu_reset_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, resetReq, protMode, clkFallEn, clkRiseEn;
  logic sysReset, procPhase, running, cycleAbort, reinitDone, ph;
  logic sawAbort, sawReinit;
  logic [3:0] period, rdIdx, i;
  logic [2:0] baseIdxSel;
  logic [15:0] offset, rdData, d;
  logic [15:0] mdl [16];
  logic [23:0] effAddr;
  reg_wr_s regWr;
  pins_s pins;
  wr_size_e s;
  int err_count, n_compared, cyc, seed = 32'h7a3c;
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  clk_gen_model clk_gen_model_inst (.core_clk(core_clk), .rstn(rstn),
    .resetReq(resetReq), .period(period), .clkFallEn(clkFallEn),
    .clkRiseEn(clkRiseEn), .sysReset(sysReset));
  cpu_reset_core #(.INIT_CYCLES(4)) cpu_reset_core_inst (
    .core_clk(core_clk), .rstn(rstn), .sysReset(sysReset),
    .clkFallEn(clkFallEn), .clkRiseEn(clkRiseEn), .regWr(regWr),
    .rdIdx(rdIdx), .baseIdxSel(baseIdxSel), .protMode(protMode),
    .offset(offset), .pins(pins), .rdData(rdData), .effAddr(effAddr),
    .procPhase(procPhase), .running(running), .cycleAbort(cycleAbort),
    .reinitDone(reinitDone));
  always @(posedge core_clk) begin
    cyc++;
    if (cycleAbort === 1'b1) sawAbort = 1;
    if (reinitDone === 1'b1) sawReinit = 1;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  task automatic wr(input logic [3:0] ix, wr_size_e sz, logic [15:0] v);
    @(negedge core_clk);
    regWr = '{1'b1, ix, sz, v};
    @(negedge core_clk);
    regWr.en = 1'b0;
  endtask : wr
  task automatic chk_all();
    for (int k = 0; k < 16; k++) begin
      @(negedge core_clk);
      rdIdx = 4'(k);
      @(negedge core_clk);
      `CHK("rdData", mdl[k], rdData)
    end
  endtask : chk_all
  task automatic sys_rst(input int falls);
    resetReq = 1;
    repeat (falls) @(posedge clkFallEn);
    @(negedge core_clk);
    resetReq = 0;
    repeat (3000) begin
      @(negedge core_clk);
      if (running === 1'b1) break;
    end
    `CHK("running", 1'b1, running)
  endtask : sys_rst
  function automatic logic [15:0] merge(logic [15:0] o, wr_size_e sz,
                                        logic [15:0] v);
    return sz == WR_LOW ? {o[15:8], v[7:0]} :
           sz == WR_HIGH ? {v[15:8], o[7:0]} : v;
  endfunction : merge
  function automatic logic [23:0] ea(logic [2:0] sel, logic [15:0] off,
                                     logic pm);
    logic [15:0] bi;
    logic [23:0] sum;
    case (sel)
      3'h0:    bi = mdl[3] + mdl[6];
      3'h1:    bi = mdl[3] + mdl[7];
      3'h2:    bi = mdl[5] + mdl[6];
      3'h3:    bi = mdl[5] + mdl[7];
      3'h4:    bi = mdl[6];
      3'h5:    bi = mdl[7];
      3'h6:    bi = mdl[5];
      default: bi = mdl[3];
    endcase
    sum = {8'h00, 16'(off + bi)};
    if (!pm) sum = ({4'h0, mdl[11], 4'h0} + sum) & `REAL_ADDR_MASK;
    return sum;
  endfunction : ea
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    {rstn, protMode, baseIdxSel, offset, rdIdx, sawAbort} = '0;
    regWr = '0;
    resetReq = 1;
    period = 4'h4;
    repeat (6) @(negedge core_clk);
    rstn = 1;
    repeat (100) @(negedge core_clk);
    `CHK("pins", 32'hFFFFFFF8, pins)
    `CHK("running", 1'b0, running)
    wr(4'h0, WR_WORD, 16'h1234);
    sys_rst(0);
    `CHK("addr", `POWERON_ADDR, pins.addr)
    `CHK("busStatus0", 1'b0, pins.busStatus0)
    foreach (mdl[k]) mdl[k] = `REG_RESET;
    mdl[13] = `MSW_RESET;
    mdl[14] = `IP_RESET;
    mdl[9] = `CODE_SEG_RESET;
    chk_all();
    for (int k = 8; k < 13; k++) begin
      mdl[k] = 16'($random(seed));
      wr(4'(k), WR_WORD, mdl[k]);
    end
    $display("reset release test done");
    repeat (60) begin
      {i, d, baseIdxSel, protMode} = 24'($random(seed));
      offset = 16'($random(seed));
      s = WR_WORD;
      if (i < 4 && d[0]) s = d[1] ? WR_HIGH : WR_LOW;
      if (s != WR_WORD) d[15:8] = d[7:0];
      if (i != 4'hF) mdl[i] = merge(mdl[i], s, d);
      wr(i, s, d);
      @(negedge core_clk);
      if (!protMode) `CHK("effAddr", 4'h0, effAddr[23:20])
      `CHK("effAddr", ea(baseIdxSel, offset, protMode), effAddr)
    end
    chk_all();
    $display("register test done");
    // stop once in each phase, one fall apart
    repeat (2) begin
      @(posedge clkFallEn);
      @(negedge core_clk);
      period = 4'h0;
      repeat (3) @(negedge core_clk);
      ph = procPhase;
      repeat (300) @(negedge core_clk);
      `CHK("procPhase", ph, procPhase)
      chk_all();
      period = 4'($random(seed)) | 4'h2;
    end
    $display("clock stop test done");
    sawReinit = 0;
    sawAbort = 0;
    sys_rst(6);
    repeat (100) @(negedge core_clk);
    `CHK("sawAbort", 1'b1, sawAbort)
    `CHK("sawReinit", 1'b0, sawReinit)
    chk_all();
    sys_rst(22);
    `CHK("sawReinit", 1'b1, sawReinit)
    for (int k = 0; k < 8; k++) mdl[k] = `REG_RESET;
    mdl[13] = `MSW_RESET;
    mdl[14] = `IP_RESET;
    for (int k = 8; k < 13; k++) begin
      wr(4'(k), WR_WORD, mdl[k]);
    end
    chk_all();
    $display("reset length test done");
    summarize();
  end
endmodule : testbench
